// ---- pcs_page_pkg.sv ----
// constants for the mac-side serdes pcs register page
package pcs_page_pkg;

  // register indexes; byte address is four times the index
  localparam logic [4:0] IDX_STD_LAST     = 5'h0F;
  localparam logic [4:0] IDX_PCS_CONTROL  = 5'h10;
  localparam logic [4:0] IDX_PCS_STATUS   = 5'h11;
  localparam logic [4:0] IDX_ADV_CODEWORD = 5'h12;
  localparam logic [4:0] IDX_LP_CODEWORD  = 5'h13;
  localparam logic [4:0] IDX_SYNC_STATUS  = 5'h14;
  localparam logic [4:0] IDX_PAGE_SELECT  = 5'h1F;

  // page select values
  localparam logic [15:0] PAGE_MAIN  = 16'h0000;
  localparam logic [15:0] PAGE_THREE = 16'h0003;

  // control field positions
  localparam int CTL_IF_DISABLE  = 15;
  localparam int CTL_IF_RESTART  = 14;
  localparam int CTL_PAR_DETECT  = 13;
  localparam int CTL_AN_RESTART  = 12;
  localparam int CTL_FORCE_ADV   = 11;
  localparam int CTL_PRE_HI      = 10;
  localparam int CTL_PRE_LO      = 8;
  localparam int CTL_AN_ENABLE   = 7;
  localparam int CTL_RX_INVERT   = 6;
  localparam int CTL_TX_INVERT   = 5;

  // status field positions
  localparam int STS_LP_RESTART  = 11;
  localparam int SYNC_SIG_DETECT = 14;
  localparam int SYNC_QSGMII     = 13;

  // writable control bits (bit 12 self-clears, 4:0 reserved)
  localparam logic [15:0] CTL_WMASK   = 16'hEFE0;
  localparam logic [15:0] CTL_RESET   = 16'h0100;
  localparam logic [15:0] ADV_RESET   = 16'h0000;
  localparam logic [15:0] STD_RESET   = 16'h0000;

  // preamble modes
  localparam logic [2:0] PRE_NONE = 3'h0;
  localparam logic [2:0] PRE_ONE  = 3'h1;
  localparam logic [2:0] PRE_TWO  = 3'h2;
  localparam logic [7:0] PRE_BYTE = 8'h55;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// ---- reg_access_if.sv ----
// single-cycle register access between bus front end and register page
interface reg_access_if;
  logic        req;
  logic        we;
  logic [4:0]  idx;
  logic        mapped;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport master (output req, output we, output idx, output mapped, output wdata,
                  input rdata);
  modport slave  (input req, input we, input idx, input mapped, input wdata,
                  output rdata);
endinterface

// ---- ahb_reg_front.sv ----
// ahb-lite slave turning word transfers into register accesses
module ahb_reg_front (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  reg_access_if.master     rbus
);
  import pcs_page_pkg::*;

  logic        pend;
  logic        pend_we;
  logic [4:0]  pend_idx;
  logic        pend_mapped;

  // one wait state: the access is made in the first data-phase cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend        <= 1'b0;
      pend_we     <= 1'b0;
      pend_idx    <= 5'h00;
      pend_mapped <= 1'b0;
    end else begin
      pend <= hsel && hready && htrans == HTRANS_NONSEQ;
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
        pend_we     <= hwrite;
        pend_idx    <= haddr[6:2];
        pend_mapped <= haddr[31:7] == 25'h0000000;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !(hsel && hready && htrans == HTRANS_NONSEQ);
      hresp     <= 1'b0;
      if (pend) begin
        hrdata <= {16'h0000, rbus.rdata};
      end
    end
  end

  assign rbus.req    = pend;
  assign rbus.we     = pend_we;
  assign rbus.idx    = pend_idx;
  assign rbus.mapped = pend_mapped;
  assign rbus.wdata  = hwdata[15:0];
endmodule

// ---- preamble_insert.sv ----
// sgmii 10/100 start-of-packet preamble byte insertion
module preamble_insert (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] mode,
  input  wire logic       in_valid,
  input  wire logic       in_sop,
  input  wire logic       in_eop,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  output logic            out_valid,
  output logic            out_sop,
  output logic            out_eop,
  output logic [7:0]      out_data
);
  import pcs_page_pkg::*;

  typedef enum logic [2:0] {ST_PASS, ST_WAIT2, ST_EMIT0, ST_EMIT1, ST_EMIT2} pre_state_t;

  pre_state_t state;
  pre_state_t next_state;
  logic [7:0] held1;
  logic [7:0] held2;
  logic       held1_eop;
  logic       held2_eop;
  logic       have2;
  logic       take;

  assign take = in_valid && in_ready;

  always_comb begin
    next_state = state;
    case (state)
      ST_PASS: begin
        if (take && in_sop && (mode == PRE_ONE || mode == PRE_TWO) && in_data != PRE_BYTE) begin
          next_state = (mode == PRE_TWO && !in_eop) ? ST_WAIT2 : ST_EMIT1;
        end
      end
      ST_WAIT2: begin
        if (take) begin
          next_state = (in_data != PRE_BYTE) ? ST_EMIT0 : ST_EMIT1;
        end
      end
      ST_EMIT0: next_state = ST_EMIT1;
      ST_EMIT1: next_state = have2 ? ST_EMIT2 : ST_PASS;
      default:  next_state = ST_PASS;
    endcase
  end

  // [RULE10] one leading byte
  // [RULE11] second byte after lookahead
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_PASS;
      in_ready  <= 1'b1;
      held1     <= 8'h00;
      held2     <= 8'h00;
      held1_eop <= 1'b0;
      held2_eop <= 1'b0;
      have2     <= 1'b0;
      out_valid <= 1'b0;
      out_sop   <= 1'b0;
      out_eop   <= 1'b0;
      out_data  <= 8'h00;
    end else begin
      state     <= next_state;
      in_ready  <= next_state == ST_PASS || next_state == ST_WAIT2;
      out_valid <= 1'b0;
      out_sop   <= 1'b0;
      out_eop   <= 1'b0;
      case (state)
        ST_PASS: begin
          if (take && next_state != ST_PASS) begin
            held1     <= in_data;
            held1_eop <= in_eop;
            have2     <= 1'b0;
            out_valid <= 1'b1;
            out_sop   <= 1'b1;
            out_data  <= PRE_BYTE;
          end else if (take) begin
            out_valid <= 1'b1;
            out_sop   <= in_sop;
            out_eop   <= in_eop;
            out_data  <= in_data;
          end
        end
        ST_WAIT2: begin
          if (take) begin
            held2     <= in_data;
            held2_eop <= in_eop;
            have2     <= 1'b1;
          end
        end
        ST_EMIT0: begin
          out_valid <= 1'b1;
          out_data  <= PRE_BYTE;
        end
        ST_EMIT1: begin
          out_valid <= 1'b1;
          out_eop   <= held1_eop;
          out_data  <= held1;
        end
        default: begin
          out_valid <= 1'b1;
          out_eop   <= held2_eop;
          out_data  <= held2;
        end
      endcase
    end
  end
endmodule

// ---- mac_serdes_pcs_page_regs.sv ----
// mac-side serdes pcs register page with page select and ahb-lite access
//
// Contract
// [RULE1] page select 3 maps addresses 16..30 onto the page-3 set
// [RULE2] addresses 0..15 always reach the standard registers
// [RULE3] page select 0 returns 16..30 to the main register space
// [RULE4] bit 15 disables mac interface while media link is down
// [RULE5] bit 14 restarts mac interface on every media link change
// [RULE6] bit 13 enables parallel detection during autonegotiation
// [RULE7] writing 1 to bit 12 restarts autonegotiation; bit self-clears
// [RULE8] bit 11 set sends advertised register as the code word
// [RULE9] advertised register resets to zero, writable only with bit 11 set
// [RULE10] preamble 000 no change, 001 prepends 0x55 when needed
// [RULE11] preamble 010 may prepend a second 0x55; 011..111 reserved
// [RULE12] bit 7 enables serdes autonegotiation
// [RULE13] bit 6 inverts the receive polarity toward the mac
// [RULE14] bit 5 inverts the transmit polarity from the mac
// [RULE15] status bit 11 shows a partner restart request occurred
// [RULE16] status 9:8 zero without remote fault, nonzero with it
// [RULE17] status 7..4 show asym pause, sym pause, full, half duplex
// [RULE18] status bit 3 shows partner autonegotiation capable
// [RULE19] status 2,1,0 show link, autonegotiation done, signal detect
// [RULE20] partner register holds last received code word, read only
// [RULE21] sync bit 14 latches signal detect, clears when read
// [RULE22] sync bit 13 shows current qsgmii code-group sync
// [RULE23] reserved bits and page-3 addresses 21..30 read zero
module mac_serdes_pcs_page_regs (
  input  wire logic        clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // media and pcs state
  input  wire logic        media_link_up,
  input  wire logic        link_partner_restart_req,
  input  wire logic [1:0]  mac_remote_fault,
  input  wire logic [3:0]  mac_adv_abilities,
  input  wire logic        link_partner_an_capable,
  input  wire logic        mac_link_up,
  input  wire logic        autonegotiation_done,
  input  wire logic        pcs_signal_detect,
  input  wire logic        serdes_signal_detect,
  input  wire logic        qsgmii_sync,
  input  wire logic [15:0] default_codeword,
  input  wire logic        rx_codeword_valid,
  input  wire logic [15:0] rx_codeword,
  // pcs controls
  output logic             mac_if_disable,
  output logic             mac_if_restart,
  output logic             parallel_detection_en,
  output logic             autonegotiation_restart,
  output logic             autonegotiation_en,
  output logic [15:0]      tx_codeword,
  output logic             rx_invert,
  output logic             tx_invert,
  // 10/100 packet byte stream
  input  wire logic        pkt_in_valid,
  input  wire logic        pkt_in_sop,
  input  wire logic        pkt_in_eop,
  input  wire logic [7:0]  pkt_in_data,
  output logic             pkt_in_ready,
  output logic             pkt_out_valid,
  output logic             pkt_out_sop,
  output logic             pkt_out_eop,
  output logic [7:0]       pkt_out_data
);
  import pcs_page_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // bus front end

  reg_access_if rbus ();

  ahb_reg_front u_front (
    .clk       (clk),
    .nrst      (nrst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .rbus      (rbus)
  );

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  logic [15:0] page_select;
  logic [15:0] std_regs  [0:15];
  logic [15:0] main_regs [16:30];
  logic [15:0] pcs_control;
  logic [15:0] adv_codeword;
  logic [15:0] lp_codeword;
  logic        lp_restart_seen;
  logic        sig_detect_seen;
  logic        media_link_q;
  logic [15:0] pcs_status;
  logic [15:0] sync_status;
  logic        wr;
  logic        rd;

  // [RULE1] page-3 routing
  // [RULE2] low addresses never paged
  // [RULE3] other pages go to main space
  function automatic logic in_page3(input logic [4:0] idx, input logic [15:0] page);
    in_page3 = idx > IDX_STD_LAST && idx != IDX_PAGE_SELECT && page == PAGE_THREE;
  endfunction

  function automatic logic in_main_hi(input logic [4:0] idx, input logic [15:0] page);
    in_main_hi = idx > IDX_STD_LAST && idx != IDX_PAGE_SELECT && page != PAGE_THREE;
  endfunction

  assign wr = rbus.req && rbus.we && rbus.mapped;
  assign rd = rbus.req && !rbus.we && rbus.mapped;

  //////////////////////////////////////////////////////////////////////////////
  // page select and standard storage

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_select <= PAGE_MAIN;
    end else if (wr && rbus.idx == IDX_PAGE_SELECT) begin
      page_select <= rbus.wdata;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_std
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          std_regs[gi] <= STD_RESET;
        end else if (wr && rbus.idx == 5'(gi)) begin
          std_regs[gi] <= rbus.wdata;
        end
      end
    end
    for (gi = 16; gi < 31; gi++) begin : g_main
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          main_regs[gi] <= STD_RESET;
        end else if (wr && rbus.idx == 5'(gi) && in_main_hi(rbus.idx, page_select)) begin
          main_regs[gi] <= rbus.wdata;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // page-3 control and advertised code word

  // [RULE4] [RULE5] [RULE6] stored control bits
  // [RULE12] [RULE13] [RULE14] mode bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pcs_control <= CTL_RESET;
    end else if (wr && rbus.idx == IDX_PCS_CONTROL && in_page3(rbus.idx, page_select)) begin
      pcs_control <= rbus.wdata & CTL_WMASK;
    end
  end

  // [RULE9] writable only while forced
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      adv_codeword <= ADV_RESET;
    end else if (wr && rbus.idx == IDX_ADV_CODEWORD && in_page3(rbus.idx, page_select)
                 && pcs_control[CTL_FORCE_ADV]) begin
      adv_codeword <= rbus.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // captured partner state

  // [RULE20] last received code word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lp_codeword <= 16'h0000;
    end else if (rx_codeword_valid) begin
      lp_codeword <= rx_codeword;
    end
  end

  // [RULE15] restart request latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lp_restart_seen <= 1'b0;
    end else if (link_partner_restart_req) begin
      lp_restart_seen <= 1'b1;
    end else if (rd && rbus.idx == IDX_PCS_STATUS && in_page3(rbus.idx, page_select)) begin
      lp_restart_seen <= 1'b0;
    end
  end

  // [RULE21] sticky detect, set beats read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sig_detect_seen <= 1'b0;
    end else if (serdes_signal_detect) begin
      sig_detect_seen <= 1'b1;
    end else if (rd && rbus.idx == IDX_SYNC_STATUS && in_page3(rbus.idx, page_select)) begin
      sig_detect_seen <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data

  // [RULE16] [RULE17] [RULE18] [RULE19] status layout
  always_comb begin
    pcs_status                 = 16'h0000;
    pcs_status[STS_LP_RESTART] = lp_restart_seen;
    pcs_status[9:8]            = mac_remote_fault;
    pcs_status[7:4]            = mac_adv_abilities;
    pcs_status[3]              = link_partner_an_capable;
    pcs_status[2]              = mac_link_up;
    pcs_status[1]              = autonegotiation_done;
    pcs_status[0]              = pcs_signal_detect;
  end

  // [RULE22] live sync level
  always_comb begin
    sync_status                  = 16'h0000;
    sync_status[SYNC_SIG_DETECT] = sig_detect_seen;
    sync_status[SYNC_QSGMII]     = qsgmii_sync;
  end

  // [RULE23] reserved space reads zero
  always_comb begin
    rbus.rdata = 16'h0000;
    if (!rbus.mapped) begin
      rbus.rdata = 16'h0000;
    end else if (rbus.idx <= IDX_STD_LAST) begin
      rbus.rdata = std_regs[rbus.idx[3:0]];
    end else if (rbus.idx == IDX_PAGE_SELECT) begin
      rbus.rdata = page_select;
    end else if (in_main_hi(rbus.idx, page_select)) begin
      rbus.rdata = main_regs[rbus.idx];
    end else if (rbus.idx == IDX_PCS_CONTROL) begin
      rbus.rdata = pcs_control;
    end else if (rbus.idx == IDX_PCS_STATUS) begin
      rbus.rdata = pcs_status;
    end else if (rbus.idx == IDX_ADV_CODEWORD) begin
      rbus.rdata = adv_codeword;
    end else if (rbus.idx == IDX_LP_CODEWORD) begin
      rbus.rdata = lp_codeword;
    end else if (rbus.idx == IDX_SYNC_STATUS) begin
      rbus.rdata = sync_status;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pcs control outputs

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      media_link_q <= 1'b0;
    end else begin
      media_link_q <= media_link_up;
    end
  end

  // [RULE4] disable while link down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mac_if_disable <= 1'b0;
    end else begin
      mac_if_disable <= pcs_control[CTL_IF_DISABLE] && !media_link_up;
    end
  end

  // [RULE5] pulse on link change
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mac_if_restart <= 1'b0;
    end else begin
      mac_if_restart <= pcs_control[CTL_IF_RESTART] && (media_link_up != media_link_q);
    end
  end

  // [RULE7] restart pulse, never stored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      autonegotiation_restart <= 1'b0;
    end else begin
      autonegotiation_restart <= wr && rbus.idx == IDX_PCS_CONTROL
                                 && in_page3(rbus.idx, page_select)
                                 && rbus.wdata[CTL_AN_RESTART];
    end
  end

  // [RULE6] [RULE12] [RULE13] [RULE14] mode outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      parallel_detection_en <= 1'b0;
      autonegotiation_en    <= 1'b0;
      rx_invert             <= 1'b0;
      tx_invert             <= 1'b0;
    end else begin
      parallel_detection_en <= pcs_control[CTL_PAR_DETECT];
      autonegotiation_en    <= pcs_control[CTL_AN_ENABLE];
      rx_invert             <= pcs_control[CTL_RX_INVERT];
      tx_invert             <= pcs_control[CTL_TX_INVERT];
    end
  end

  // [RULE8] forced code word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_codeword <= 16'h0000;
    end else begin
      tx_codeword <= pcs_control[CTL_FORCE_ADV] ? adv_codeword : default_codeword;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // preamble insertion; reserved modes pass packets untouched

  preamble_insert u_pre (
    .clk       (clk),
    .nrst      (nrst),
    .mode      (pcs_control[CTL_PRE_HI:CTL_PRE_LO]),
    .in_valid  (pkt_in_valid),
    .in_sop    (pkt_in_sop),
    .in_eop    (pkt_in_eop),
    .in_data   (pkt_in_data),
    .in_ready  (pkt_in_ready),
    .out_valid (pkt_out_valid),
    .out_sop   (pkt_out_sop),
    .out_eop   (pkt_out_eop),
    .out_data  (pkt_out_data)
  );

  // hsize unused: only whole-word transfers are issued
  logic hsize_unused;
  assign hsize_unused = ^hsize;
endmodule

// ---- pcs_page_chk.sv ----
// pcs page assertions
module pcs_page_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        media_link_up,
  input wire logic        mac_if_disable,
  input wire logic        mac_if_restart,
  input wire logic        parallel_detection_en,
  input wire logic        autonegotiation_restart,
  input wire logic        autonegotiation_en,
  input wire logic        rx_invert,
  input wire logic        tx_invert,
  input wire logic        pkt_in_ready,
  input wire logic        pkt_out_valid,
  input wire logic        pkt_out_sop,
  input wire logic [7:0]  pkt_out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_page_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_bus_wait: assert property ((hsel && hready && htrans == HTRANS_NONSEQ) |=>
    !hreadyout ##1 hreadyout) else $error("wait state wrong");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_if_disable: assert property (mac_if_disable |-> $past(!media_link_up))
    else $error("disable with link up");
  a_if_restart: assert property (mac_if_restart |->
    $past(media_link_up) != $past(media_link_up, 2)) else $error("restart without link change");
  a_restart_once: assert property (autonegotiation_restart |=> !autonegotiation_restart)
    else $error("restart pulse too long");
  a_restart_cause: assert property (autonegotiation_restart |->
    $past(hwdata[12]) || $past(hwdata[12], 2)) else $error("restart without write");
  a_ctl_write: assert property ($changed({parallel_detection_en, autonegotiation_en,
    rx_invert, tx_invert}) |-> $past(!hreadyout) || $past(!hreadyout, 2) ||
    $past(!hreadyout, 3)) else $error("control changed without write");
  a_pkt_refuse: assert property (!pkt_in_ready |=> pkt_out_valid)
    else $error("stall without output");
  c_if_restart: cover property (mac_if_restart);
  c_an_restart: cover property (autonegotiation_restart);
  c_preamble: cover property (pkt_out_valid && pkt_out_sop && pkt_out_data == 8'h55);
endmodule

bind mac_serdes_pcs_page_regs pcs_page_chk u_pcs_page_chk (.*);

// ---- mac_partner.sv ----
// host mac model
module mac_partner (
  input  wire logic       clk,
  input  wire logic       pkt_in_ready,
  output logic [9:0]      status_lv,
  output logic            restart_req,
  output logic            serdes_detect,
  output logic            sync_ok,
  output logic            cw_valid,
  output logic [15:0]     cw,
  output logic            pkt_valid,
  output logic            pkt_sop,
  output logic            pkt_eop,
  output logic [7:0]      pkt_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {status_lv, restart_req, serdes_detect, sync_ok, cw_valid, pkt_valid, pkt_sop, pkt_eop} = 17'h0;
    cw = 16'hFFFF;
    pkt_data = 8'hFF;
  end
  task automatic announce(input logic [9:0] lv, input logic [15:0] word);
    status_lv <= lv;
    {restart_req, serdes_detect, sync_ok, cw_valid} <= 4'hF;
    cw <= word;
    @(posedge clk);
    {restart_req, serdes_detect, cw_valid} <= 3'h0;
    cw <= ~word;
    @(posedge clk);
  endtask
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      pkt_valid <= 1'b1;
      pkt_sop <= (i == 0);
      pkt_eop <= (i == b.size() - 1);
      pkt_data <= b[i];
      @(negedge clk);
      while (!pkt_in_ready) @(negedge clk);
      @(posedge clk);
    end
    {pkt_valid, pkt_sop, pkt_eop} <= 3'h0;
    pkt_data <= ~pkt_data;
  endtask
endmodule

// ---- mac_serdes_pcs_page_regs_tb.sv ----
// pcs register page bench
module mac_serdes_pcs_page_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_page_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, media_link_up = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, hready, mac_if_disable, mac_if_restart, parallel_detection_en;
  logic autonegotiation_restart, autonegotiation_en, rx_invert, tx_invert, pkt_in_ready;
  logic link_partner_restart_req, serdes_signal_detect, qsgmii_sync, rx_codeword_valid;
  logic pkt_in_valid, pkt_in_sop, pkt_in_eop, pkt_out_valid, pkt_out_sop, pkt_out_eop;
  logic [9:0] st;
  logic [15:0] rx_codeword, tx_codeword, rd, restarts = 16'h0000;
  logic [7:0] pkt_in_data, pkt_out_data, seen_q[$];
  int err_count = 0, comparisons = 0;
  localparam logic [24:0] ROWS [18] = '{
    {1'b0, 8'h40, 16'h0000}, {1'b1, 8'h14, 16'h1357}, {1'b1, 8'h7C, 16'h0003},
    {1'b0, 8'h14, 16'h1357}, {1'b0, 8'h40, 16'h0100}, {1'b0, 8'h48, 16'h0000},
    {1'b1, 8'h48, 16'h1234}, {1'b0, 8'h48, 16'h0000}, {1'b1, 8'h40, 16'hFFFF},
    {1'b0, 8'h40, 16'hEFE0}, {1'b1, 8'h48, 16'hA5A5}, {1'b0, 8'h48, 16'hA5A5},
    {1'b0, 8'h54, 16'h0000}, {1'b1, 8'h54, 16'hFFFF}, {1'b0, 8'h54, 16'h0000},
    {1'b0, 8'h80, 16'h0000}, {1'b1, 8'h7C, 16'h0000}, {1'b0, 8'h40, 16'h0000}};
  assign hready = hreadyout;
  always #2 clk = ~clk;
  always @(posedge clk) restarts <= restarts + {7'h0, autonegotiation_restart === 1'b1,
    7'h0, mac_if_restart === 1'b1};
  always @(posedge clk) if (pkt_out_valid === 1'b1) seen_q.push_back(pkt_out_data);
  mac_serdes_pcs_page_regs u_mac_serdes_pcs_page_regs (.clk, .nrst, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hready, .hwdata, .hreadyout, .hrdata, .hresp, .media_link_up,
    .link_partner_restart_req, .mac_remote_fault(st[9:8]), .mac_adv_abilities(st[7:4]),
    .link_partner_an_capable(st[3]), .mac_link_up(st[2]), .autonegotiation_done(st[1]),
    .pcs_signal_detect(st[0]), .serdes_signal_detect, .qsgmii_sync,
    .default_codeword(16'hC3C3), .rx_codeword_valid, .rx_codeword, .mac_if_disable,
    .mac_if_restart, .parallel_detection_en, .autonegotiation_restart, .autonegotiation_en,
    .tx_codeword, .rx_invert, .tx_invert, .pkt_in_valid, .pkt_in_sop, .pkt_in_eop,
    .pkt_in_data, .pkt_in_ready, .pkt_out_valid, .pkt_out_sop, .pkt_out_eop, .pkt_out_data);
  mac_partner u_mac_partner (.clk, .pkt_in_ready, .status_lv(st),
    .restart_req(link_partner_restart_req), .serdes_detect(serdes_signal_detect),
    .sync_ok(qsgmii_sync), .cw_valid(rx_codeword_valid), .cw(rx_codeword),
    .pkt_valid(pkt_in_valid), .pkt_sop(pkt_in_sop), .pkt_eop(pkt_in_eop),
    .pkt_data(pkt_in_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(negedge clk);
    while (!hreadyout) @(negedge clk);
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    @(negedge clk);
    while (!hreadyout) @(negedge clk);
    r = hrdata[15:0];
    @(posedge clk);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [15:0] exp);
    ahb(1'b0, a, 16'h0000, rd);
    chk(rd, exp);
  endtask
  task automatic pkt(input logic [7:0] b[$], input logic [7:0] e[$]);
    seen_q.delete();
    u_mac_partner.send(b);
    repeat (6) @(posedge clk);
    chk(16'(seen_q.size()), 16'(e.size()));
    foreach (e[i]) chk({8'h00, seen_q[i]}, {8'h00, e[i]});
  endtask
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (ROWS[i]) begin
      ahb(ROWS[i][24], {24'h0, ROWS[i][23:16]}, ROWS[i][15:0], rd);
      if (!ROWS[i][24]) chk(rd, ROWS[i][15:0]);
    end
    chk(tx_codeword, 16'hA5A5);
    chk({12'h000, parallel_detection_en, autonegotiation_en, rx_invert, tx_invert}, 16'h000F);
    media_link_up <= 1'b1;
    repeat (4) @(posedge clk);
    chk({15'h0, mac_if_disable}, 16'h0000);
    media_link_up <= 1'b0;
    repeat (4) @(posedge clk);
    chk({15'h0, mac_if_disable}, 16'h0001);
    chk(restarts, 16'h0102);
    ahb(1'b1, 32'h7C, 16'h0003, rd);
    u_mac_partner.announce(10'h2AD, 16'h4321);
    rchk(32'h44, 16'h0AAD);
    rchk(32'h44, 16'h02AD);
    rchk(32'h4C, 16'h4321);
    rchk(32'h50, 16'h6000);
    rchk(32'h50, 16'h2000);
    ahb(1'b1, 32'h40, 16'h0200, rd);
    pkt('{8'h12, 8'h34, 8'h56}, '{8'h55, 8'h55, 8'h12, 8'h34, 8'h56});
    pkt('{8'h12, 8'h55, 8'h34}, '{8'h55, 8'h12, 8'h55, 8'h34});
    ahb(1'b1, 32'h40, 16'h0100, rd);
    pkt('{8'h12, 8'h34}, '{8'h55, 8'h12, 8'h34});
    pkt('{8'h55, 8'h34}, '{8'h55, 8'h34});
    ahb(1'b1, 32'h40, 16'h0000, rd);
    pkt('{8'h12, 8'h34}, '{8'h12, 8'h34});
    ahb(1'b1, 32'h40, 16'h0300, rd);
    pkt('{8'h12, 8'h34}, '{8'h12, 8'h34});
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rchk(32'h40, 16'h0000);
    ahb(1'b1, 32'h7C, 16'h0003, rd);
    rchk(32'h40, 16'h0100);
    rchk(32'h48, 16'h0000);
    end_sim();
  end
endmodule
